// [hw/asr_host.sv]
`default_nettype none
// Behaviour
// - Write strobe held high during reads
// - Write pulse at least minimum width
// - Select active long before write end
// - Address valid before write starts
// - Address held after write ends
// - Data valid before write end
// - Address valid long before write end
// - Never drive against device outputs
// - High select low lets inputs float
// - Low-select retention holds high select firm
// - Deselect before retention, wait cycle after
module asr_host (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // User request side
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [12:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic ret_req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   output logic ret_active,
   // Memory pins
   output logic [12:0] mem_addr,
   output logic select_low_active_n,
   output logic select_high_active,
   output logic write_strobe_n,
   output logic output_gate_n,
   input wire logic [7:0] mem_data_in,
   output logic [7:0] mem_data_out,
   output logic mem_data_oe_n
);
   // Reset release synchroniser
   logic rst_s1_q, rst_s2_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire logic rst_sync_n = rst_s2_q;

   // Pin data passes two flops before use
   logic [7:0] din_s1_q, din_s2_q;
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         din_s1_q <= 8'h00;
         din_s2_q <= 8'h00;
      end else begin
         din_s1_q <= mem_data_in;
         din_s2_q <= din_s1_q;
      end
   end

   // Sequencer state and its cycle counter
   asr_pkg::asr_state_e state_q;
   logic [3:0] cnt_q; // Cycles spent in current phase
   logic [3:0] cyc_q; // Cycles since the access began
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= asr_pkg::ASR_IDLE;
         cnt_q <= asr_pkg::CNT_ZERO;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         case (state_q)
            asr_pkg::ASR_IDLE: begin
               cnt_q <= asr_pkg::CNT_ZERO;
               if (ret_req) begin
                  // Already deselected here, so entry is immediate
                  state_q <= asr_pkg::ASR_RET;
               end else if (req_valid && req_write) begin
                  state_q <= asr_pkg::ASR_WR_SETUP;
               end else if (req_valid) begin
                  state_q <= asr_pkg::ASR_RD_ACC;
               end
            end
            asr_pkg::ASR_RD_ACC: begin
               // Wait access time plus two synchroniser cycles
               if (cnt_q == 4'(asr_pkg::ACC_CYC + 1)) begin
                  state_q <= asr_pkg::ASR_RD_DONE;
               end
            end
            asr_pkg::ASR_RD_DONE: begin
               state_q <= asr_pkg::ASR_IDLE;
            end
            asr_pkg::ASR_WR_SETUP: begin
               // One cycle of address lead before the strobe
               state_q <= asr_pkg::ASR_WR_PULSE;
               cnt_q <= asr_pkg::CNT_ZERO;
            end
            asr_pkg::ASR_WR_PULSE: begin
               if (cnt_q == 4'(asr_pkg::WR_HOLD_CYC - 1)) begin
                  state_q <= asr_pkg::ASR_WR_REC;
                  cnt_q <= asr_pkg::CNT_ZERO;
               end
            end
            asr_pkg::ASR_WR_REC: begin
               // Address and data held; also pads the cycle time
               if (cnt_q == 4'(asr_pkg::REC_CYC)) begin
                  state_q <= asr_pkg::ASR_IDLE;
               end
            end
            asr_pkg::ASR_RET: begin
               cnt_q <= asr_pkg::CNT_ZERO;
               if (!ret_req) begin
                  state_q <= asr_pkg::ASR_RET_EXIT;
               end
            end
            asr_pkg::ASR_RET_EXIT: begin
               // Full read cycle time before the next access
               if (cnt_q == 4'(asr_pkg::CYC_MIN - 1)) begin
                  state_q <= asr_pkg::ASR_IDLE;
               end
            end
            default: begin
               state_q <= asr_pkg::ASR_IDLE;
            end
         endcase
      end
   end

   // Cycle length tracker, only read by assertions
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cyc_q <= asr_pkg::CNT_ZERO;
      end else if (state_q == asr_pkg::ASR_IDLE) begin
         cyc_q <= asr_pkg::CNT_ZERO;
      end else if (cyc_q != 4'hf) begin
         cyc_q <= cyc_q + 4'h1;
      end
   end

   // Address and write data latch at request acceptance
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mem_addr <= 13'h0000;
         mem_data_out <= 8'h00;
      end else if (state_q == asr_pkg::ASR_IDLE && req_valid
                   && !ret_req) begin
         mem_addr <= req_addr;
         mem_data_out <= req_wdata;
      end
   end

   // Pin controls registered from the current state, with look-ahead on idle requests and write end
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         select_low_active_n <= 1'b1;
         select_high_active <= 1'b0;
         write_strobe_n <= 1'b1;
         output_gate_n <= 1'b1;
         mem_data_oe_n <= 1'b1;
      end else begin
         // Retention parks the high select low, all else idle
         select_high_active <= !(state_q == asr_pkg::ASR_RET
            || (state_q == asr_pkg::ASR_IDLE && ret_req));
         // Low select goes active with the address; high select already on; strobe later
         select_low_active_n <= !((state_q == asr_pkg::ASR_IDLE
            && req_valid && !ret_req)
            || state_q == asr_pkg::ASR_RD_ACC
            || state_q == asr_pkg::ASR_WR_SETUP
            || (state_q == asr_pkg::ASR_WR_PULSE
                && cnt_q != 4'(asr_pkg::WR_HOLD_CYC - 1)));
         // Strobe and low select end the write on the same edge; high select stays on
         write_strobe_n <= !(state_q == asr_pkg::ASR_WR_SETUP
            || (state_q == asr_pkg::ASR_WR_PULSE
                && cnt_q != 4'(asr_pkg::WR_HOLD_CYC - 1)));
         // Gate only on reads; strobe never low then
         output_gate_n <= !((state_q == asr_pkg::ASR_IDLE
            && req_valid && !req_write && !ret_req)
            || state_q == asr_pkg::ASR_RD_ACC);
         // Data driven only while gate is off, never against outputs
         mem_data_oe_n <= !((state_q == asr_pkg::ASR_IDLE
            && req_valid && req_write && !ret_req)
            || state_q == asr_pkg::ASR_WR_SETUP
            || state_q == asr_pkg::ASR_WR_PULSE
            || state_q == asr_pkg::ASR_WR_REC);
      end
   end

   // User side answers
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         ret_active <= 1'b0;
      end else begin
         // Ready only while idle and not about to take a request
         req_ready <= state_q == asr_pkg::ASR_IDLE && !req_valid
            && !ret_req;
         rsp_valid <= state_q == asr_pkg::ASR_RD_DONE;
         // Sampled data is the stored word of this address
         if (state_q == asr_pkg::ASR_RD_DONE) begin
            rsp_rdata <= din_s2_q;
         end
         ret_active <= state_q == asr_pkg::ASR_RET;
      end
   end

   // Pin behaviour checks
   a_read_strobe_high: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      !output_gate_n |-> write_strobe_n)
      else $error("strobe low while output gate active");
   a_write_all_active: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      $fell(write_strobe_n) |-> !select_low_active_n
      && select_high_active && !mem_data_oe_n)
      else $error("write strobe without selects and data");
   // One full period already exceeds the least pulse, so the strobe
   // stays low exactly one cycle and ends cleanly after it
   a_write_pulse_width: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      $fell(write_strobe_n) |-> !write_strobe_n ##1 write_strobe_n)
      else $error("write pulse width wrong");
   a_addr_held_write: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      !write_strobe_n |=> $stable(mem_addr))
      else $error("address moved around write");
   a_data_no_fight: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      !mem_data_oe_n |-> output_gate_n)
      else $error("driving data while device outputs on");
   a_select_before_end: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      $rose(write_strobe_n) && $past(!select_low_active_n)
      |-> $past(!select_low_active_n, 2))
      else $error("select too late before write end");
   a_ret_high_sel_low: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      ret_active |-> !select_high_active
      && select_low_active_n)
      else $error("retention without high select low");
   a_read_answer_time: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      $fell(output_gate_n) |-> ##[3:5] rsp_valid)
      else $error("read answer out of time");
   a_cycle_length: assert property (@(posedge core_clk)
      disable iff (!rst_sync_n)
      $rose(state_q == asr_pkg::ASR_IDLE) && cyc_q != 4'h0
      |-> $past(cyc_q) >= 4'(asr_pkg::CYC_MIN - 1))
      else $error("access cycle shorter than minimum");
endmodule : asr_host
`default_nettype wire

// [hw/asr_pkg.sv]
`default_nettype none
package asr_pkg;
   // Geometry of the memory behind the pins
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int WORDS = 8192;
   // Core clock period in ns
   localparam int CLK_NS = 100;
   // Timing figures of the slowest grade, in ns
   localparam int READ_CYCLE_MIN_NS = 150;
   localparam int ACCESS_MAX_NS = 150;
   localparam int WRITE_PULSE_MIN_NS = 90;
   localparam int SELECT_TO_WRITE_END_MIN_NS = 100;
   localparam int ADDR_TO_WRITE_END_MIN_NS = 100;
   localparam int DATA_OVERLAP_MIN_NS = 60;
   localparam int ADDR_RECOVERY_STROBE_END_NS = 10;
   localparam int ADDR_LEAD_MIN_NS = 0;
   localparam int DESELECT_BEFORE_RETENTION_NS = 0;
   // Least times round up to whole cycles, never below one
   localparam int WR_PULSE_CYC =
      (WRITE_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_SEL_CYC =
      (SELECT_TO_WRITE_END_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_DATA_CYC =
      (DATA_OVERLAP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_HOLD_RAW =
      (WRITE_PULSE_MIN_NS > SELECT_TO_WRITE_END_MIN_NS) ?
      WR_PULSE_CYC : WR_SEL_CYC;
   localparam int WR_HOLD_CYC = (WR_HOLD_RAW < WR_DATA_CYC) ?
      WR_DATA_CYC : WR_HOLD_RAW;
   localparam int REC_RAW =
      (ADDR_RECOVERY_STROBE_END_NS + CLK_NS - 1) / CLK_NS;
   localparam int REC_CYC = (REC_RAW < 1) ? 1 : REC_RAW;
   localparam int ACC_CYC = (ACCESS_MAX_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_RAW = (READ_CYCLE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_MIN = CYC_RAW;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   // Controller sequence
   typedef enum logic [2:0] {
      ASR_IDLE, ASR_RD_ACC, ASR_RD_DONE, ASR_WR_SETUP,
      ASR_WR_PULSE, ASR_WR_REC, ASR_RET, ASR_RET_EXIT
   } asr_state_e;
endpackage : asr_pkg
`default_nettype wire

// [tb/asr_sram_model.sv]
`default_nettype none
// Behavioural 8k x 8 asynchronous memory that also times the pins
module asr_sram_model (
   // Pins from the controller
   input wire logic [12:0] addr,
   input wire logic sel_n,
   input wire logic sel_hi,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [7:0] din,
   input wire logic ctl_drv,
   // Pins back to the controller
   output logic [7:0] dout,
   output logic drv,
   output int viol_count
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:8191];
   logic armed = 1'b0; // Set only by a real write start, not by X
   realtime t_wr = 0, t_sel = 0, t_adr = 0, t_dat = 0, t_up = 0;
   realtime t_end = -1000;
   // High select gates all other inputs, so floating ones do no harm
   wire sel_on = !sel_n && sel_hi;
   wire wr_on = sel_on && !we_n;
   wire rd_on = sel_on && we_n && !oe_n;
   initial begin
      viol_count = 0;
      drv = 1'b0;
      dout = 8'h00;
   end
   // Report a timing fault of the controller
   task automatic bad(input string m);
      viol_count++;
      $display("ERROR %0t memory pins: %s", $realtime, m);
   endtask : bad
   // Selection after retention must wait a read cycle
   always @(posedge sel_hi) t_up = $realtime;
   always @(posedge sel_on) begin
      if ($realtime - t_up < 150) bad("access too soon");
      t_sel = $realtime;
   end
   always @(posedge wr_on) begin
      if (wr_on === 1'b1) begin
         t_wr = $realtime;
         armed = 1'b1;
      end
   end
   // Store at the end of the interval and check its timing
   always @(negedge wr_on) begin
      if (armed) begin
         if ($realtime - t_wr < 90) bad("short write");
         if ($realtime - t_sel < 100) bad("select late");
         if ($realtime - t_dat < 60) bad("data late");
         if ($realtime - t_adr < 100) bad("addr late");
         mem[addr] = din;
         t_end = $realtime;
         armed = 1'b0;
      end
   end
   always @(addr) begin
      if ($realtime - t_end < 10) bad("addr recovery");
      if (wr_on === 1'b1) bad("addr moved in write");
      t_adr = $realtime;
   end
   always @(din) t_dat = $realtime;
   // Transport delay keeps old data a while after an address change
   always @(addr or rd_on or wr_on) dout <= #60 mem[addr];
   // Drivers turn on late, off at once
   always @(rd_on) begin
      if (rd_on === 1'b1) drv <= #20 1'b1;
      else drv <= 1'b0;
   end
   always @(negedge we_n) if (drv) bad("strobe in read");
   always @(drv or ctl_drv) if (drv && ctl_drv) bad("bus fight");
endmodule : asr_sram_model
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
// Self-checking bench for the memory controller
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst_n, req_valid, req_write, ret_req, req_ready;
   logic rsp_valid, ret_active, select_low_active_n, select_high_active;
   logic write_strobe_n, output_gate_n, mem_data_oe_n, mdrv;
   logic [12:0] req_addr, mem_addr;
   logic [7:0] req_wdata, rsp_rdata, mem_data_out, mem_data_in, mdout;
   logic [7:0] bus_last = 8'h00; // Last level actually driven
   int viol_count;
   int num_errors = 0;
   int cmp_count = 0;
   // Corner addresses and patterns
   localparam logic [12:0] ADR [4] =
      '{13'h0000, 13'h1fff, 13'h0aa5, 13'h1555};
   localparam logic [7:0] DAT [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
   asr_host DUT (.core_clk, .rst_n, .req_valid, .req_write, .req_addr,
      .req_wdata, .ret_req, .req_ready, .rsp_valid, .rsp_rdata, .ret_active,
      .mem_addr, .select_low_active_n, .select_high_active, .write_strobe_n,
      .output_gate_n, .mem_data_in, .mem_data_out, .mem_data_oe_n);
   asr_sram_model mem_model (.addr(mem_addr), .sel_n(select_low_active_n),
      .sel_hi(select_high_active), .we_n(write_strobe_n),
      .oe_n(output_gate_n), .din(mem_data_out), .ctl_drv(!mem_data_oe_n),
      .dout(mdout), .drv(mdrv), .viol_count(viol_count));
   // A released bus shows the inverse of its last level, never a lucky one
   always @(posedge core_clk) begin
      if (!mem_data_oe_n || mdrv) bus_last <= mem_data_in;
   end
   assign mem_data_in = !mem_data_oe_n ? mem_data_out :
      mdrv ? mdout : ~bus_last;
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
      input string w);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t %s: got %h want %h", $time, w, got, exp);
      end
   endtask : cmp
   // One access; lat counts edges from acceptance to the read answer
   task automatic access(input logic wr, input logic [12:0] a,
      input logic [7:0] d, output logic [7:0] q, output int lat);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      cmp({7'h00, req_ready}, 8'h01, "ready before request");
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      @(negedge core_clk);
      req_valid = 1'b0;
      lat = 0;
      // Busy time of a write is fixed, so no ready race after it
      if (wr) repeat (6) @(negedge core_clk);
      while (!wr && rsp_valid !== 1'b1 && lat < 20) begin
         @(negedge core_clk);
         lat++;
      end
      q = rsp_rdata;
      @(negedge core_clk);
   endtask : access
   task automatic t_reset();
      cmp({3'h0, select_low_active_n, select_high_active, write_strobe_n,
         output_gate_n, mem_data_oe_n}, 8'h17, "pins in reset");
      $display("TB: reset test done");
   endtask : t_reset
   task automatic t_rw_corners();
      logic [7:0] q;
      int lat;
      for (int i = 0; i < 4; i++) access(1'b1, ADR[i], DAT[i], q, lat);
      for (int i = 3; i >= 0; i--) begin
         access(1'b0, ADR[i], 8'h00, q, lat);
         cmp(q, DAT[i], "read back");
         cmp(lat[7:0], 8'h05, "read latency");
      end
      $display("TB: corner test done");
   endtask : t_rw_corners
   // A write offered while a read runs must be ignored
   task automatic t_busy();
      logic [7:0] q;
      int lat;
      fork
         access(1'b0, ADR[0], 8'h00, q, lat);
         begin
            repeat (2) @(negedge core_clk);
            req_valid = 1'b1;
            req_write = 1'b1;
            req_wdata = 8'h3c;
            @(negedge core_clk);
            req_valid = 1'b0;
         end
      join
      cmp(q, DAT[0], "read while offered");
      access(1'b0, ADR[0], 8'h00, q, lat);
      cmp(q, DAT[0], "ignored write");
      access(1'b1, ADR[2], 8'h96, q, lat);
      access(1'b0, ADR[2], 8'h00, q, lat);
      cmp(q, 8'h96, "overwrite");
      $display("TB: busy test done");
   endtask : t_busy
   task automatic t_retention();
      logic [7:0] q;
      int lat;
      int n;
      ret_req = 1'b1;
      n = 0;
      while (ret_active !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      cmp({5'h00, ret_active, select_high_active, select_low_active_n},
         8'h05, "parked pins");
      repeat (5) @(negedge core_clk);
      ret_req = 1'b0;
      access(1'b0, ADR[1], 8'h00, q, lat);
      cmp(q, DAT[1], "kept data");
      $display("TB: retention test done");
   endtask : t_retention
   task automatic give_verdict();
      num_errors += viol_count;
      $display("TB: %0d compares, %0d errors", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // Watchdog well past the 130 or so cycles the tests need
   initial begin
      #(100 * 4000);
      num_errors++;
      $display("ERROR %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 13'h0000;
      req_wdata = 8'h00;
      ret_req = 1'b0;
      repeat (8) @(negedge core_clk);
      t_reset();
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      t_rw_corners();
      t_busy();
      t_retention();
      give_verdict();
   end
endmodule : tb
`default_nettype wire
